// >>> logic/cas_scripter.sv
// Conditional action scripter engine
// How it works
// - Sixteen pairs are held, and a write to any index at or above sixteen is refused.
// - Each pair holds one condition and one action; equal conditions in several pairs fire all.
// - A condition is true only while every subcondition selected by its mask is true.
// - Role, profile deletion and policy actions run only while the pre-init phase is on.
// - Hardware indication, set up in pre-init only, routes a chosen core signal onto a GPIO through one register.
// - Runtime actions are packet sends, counter inc/set, timer control, GPIO set, hibernate.
// - Increment adds exactly one to the chosen counter per trigger.
// - Set loads the chosen counter with the value held in the pair.
// - There are eight timers and eight counters, each independent.
// - Timers count down in whole seconds only.
// - Each counter is 32 bits wide.
// - A packet send is refused above one packet length or above eight tokens.
// - Action latency is variable; packet sends wait for the core as long as it takes.
`timescale 1ns/1ps
`default_nettype none
`include "cas_params.svh"

module cas_scripter
  import cas_pkg::*;
#(
  parameter int CYC_PER_SEC = `CAS_CYC_PER_SEC,
  parameter int MAX_PKT_LEN = `CAS_MAX_PKT_LEN,
  parameter int TMR_W       = 16
)(
  // Clock, reset, enable
  input  wire logic                            clk_sys_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            ce_i,
  // Pair configuration
  input  wire logic                            cfg_we_i,
  input  wire logic [`CAS_IDX_W:0]             cfg_idx_i,
  input  wire logic [`CAS_ENT_W-1:0]           cfg_data_i,
  output logic                                 cfg_ok_o,
  output logic                                 cfg_err_o,
  // Trigger sources
  input  wire logic                            preinit_i,
  input  wire logic [`CAS_NCOND-1:0]           cond_i,
  input  wire logic [7:0]                      core_sig_i,
  // Packet request to the networking core
  output logic                                 pkt_req_o,
  output logic [1:0]                           pkt_kind_o,
  output logic [15:0]                          pkt_len_o,
  output logic [3:0]                           pkt_tok_o,
  input  wire logic                            pkt_ack_i,
  // Action results
  output logic [7:0]                           gpio_o,
  output logic [`CAS_NCNT*`CAS_CNT_W-1:0]      cnt_o,
  output logic [`CAS_NTMR-1:0]                 tmr_exp_o,
  output logic [1:0]                           role_o,
  output logic [7:0]                           policy_o,
  output logic                                 del_prof_o,
  output logic                                 hib_o,
  output logic                                 act_err_o
);

  cas_mem_if mif ();

  cas_pair_mem #(.DEPTH(`CAS_NPAIR)) u_mem (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .port      (mif.mem)
  );

  cas_state_type            state_q;
  logic [`CAS_IDX_W-1:0]    idx_q;
  logic [`CAS_NPAIR-1:0]    prev_q;
  logic [31:0]              sec_q;
  logic                     tick;
  logic [`CAS_NTMR-1:0]     tmr_load;
  logic [`CAS_NCNT-1:0]     cnt_inc;
  logic [`CAS_NCNT-1:0]     cnt_set;
  logic [7:0]               hwind_en_q;
  logic [2:0]               hwind_sel_q [8];
  logic [7:0]               gpio_q;

  // Entry fields of the pair under evaluation
  logic                     e_valid;
  logic [23:0]              e_mask;
  cas_op_type               e_op;
  logic [2:0]               e_tgt;
  logic [31:0]              e_val;
  logic [23:0]              cond_vec;
  logic                     cond_true;
  logic                     is_pre;
  logic                     fire;
  logic                     pkt_bad;

  assign e_valid  = mif.rdata[`CAS_F_VALID];
  assign e_mask   = mif.rdata[`CAS_F_MASK_HI:`CAS_F_MASK_LO];
  assign e_op     = cas_op_type'(mif.rdata[`CAS_F_OP_HI:`CAS_F_OP_LO]);
  assign e_tgt    = mif.rdata[`CAS_F_TGT_HI:`CAS_F_TGT_LO];
  assign e_val    = mif.rdata[`CAS_F_VAL_HI:`CAS_F_VAL_LO];
  assign cond_vec = {tmr_exp_o, cond_i};
  assign cond_true = (e_mask != 24'h00_0000) && ((e_mask & ~cond_vec) == 24'h00_0000);
  assign is_pre   = (e_op == CAS_OP_ROLE) || (e_op == CAS_OP_DEL_PROF)
                 || (e_op == CAS_OP_POLICY) || (e_op == CAS_OP_HW_IND);
  // Fires on the rising edge of its own condition, one action per pair
  assign fire     = (state_q == CAS_ST_EVAL) && e_valid && cond_true && !prev_q[idx_q]
                 && (!is_pre || preinit_i);
  assign pkt_bad  = (e_val[`CAS_F_LEN_HI:0] > 16'(MAX_PKT_LEN))
                 || (e_val[`CAS_F_TOK_HI:`CAS_F_TOK_LO] > 4'(`CAS_MAX_TOKENS));

  // Configuration writes into the memory
  assign mif.we    = ce_i && cfg_we_i && !cfg_idx_i[`CAS_IDX_W];
  assign mif.waddr = cfg_idx_i[`CAS_IDX_W-1:0];
  assign mif.wdata = cfg_data_i;
  assign mif.raddr = idx_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      cfg_ok_o  <= 1'b0;
      cfg_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cfg_ok_o  <= cfg_we_i && !cfg_idx_i[`CAS_IDX_W];
      cfg_err_o <= cfg_we_i && cfg_idx_i[`CAS_IDX_W];
    end
  end

  // Scan sequencer: ascending index, one action at a time
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= CAS_ST_READ;
      idx_q   <= '0;
    end
    else if (ce_i)
    begin
      unique case (state_q)
        CAS_ST_READ: state_q <= CAS_ST_EVAL;
        CAS_ST_EVAL:
        begin
          if (fire && (e_op inside {CAS_OP_PKT_RAW, CAS_OP_PKT_UDP, CAS_OP_PKT_TCP}) && !pkt_bad)
          begin
            state_q <= CAS_ST_PKT;
          end
          else
          begin
            state_q <= CAS_ST_READ;
            idx_q   <= idx_q + 1'b1;
          end
        end
        CAS_ST_PKT:
        begin
          if (pkt_ack_i)
          begin
            state_q <= CAS_ST_READ;
            idx_q   <= idx_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Last seen condition per pair, for edge triggering
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      prev_q <= '0;
    end
    else if (ce_i && state_q == CAS_ST_EVAL)
    begin
      prev_q[idx_q] <= e_valid && cond_true && (!is_pre || preinit_i);
    end
  end

  // Packet request held until the core takes it
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pkt_req_o  <= 1'b0;
      pkt_kind_o <= 2'h0;
      pkt_len_o  <= 16'h0000;
      pkt_tok_o  <= 4'h0;
    end
    else if (ce_i)
    begin
      if (fire && (e_op inside {CAS_OP_PKT_RAW, CAS_OP_PKT_UDP, CAS_OP_PKT_TCP}) && !pkt_bad)
      begin
        pkt_req_o  <= 1'b1;
        pkt_kind_o <= 2'(e_op);
        pkt_len_o  <= e_val[`CAS_F_LEN_HI:0];
        pkt_tok_o  <= e_val[`CAS_F_TOK_HI:`CAS_F_TOK_LO];
      end
      else if (pkt_ack_i)
      begin
        pkt_req_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      act_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      act_err_o <= fire && pkt_bad
                && (e_op inside {CAS_OP_PKT_RAW, CAS_OP_PKT_UDP, CAS_OP_PKT_TCP});
    end
  end

  // Pre-init actions and hibernate
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      role_o     <= 2'h0;
      policy_o   <= 8'h00;
      del_prof_o <= 1'b0;
      hib_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      del_prof_o <= fire && (e_op == CAS_OP_DEL_PROF);
      if (fire && e_op == CAS_OP_ROLE)
      begin
        role_o <= e_val[1:0];
      end
      if (fire && e_op == CAS_OP_POLICY)
      begin
        policy_o <= e_val[7:0];
      end
      if (fire && e_op == CAS_OP_HIBERN)
      begin
        hib_o <= 1'b1;
      end
    end
  end

  // GPIO: software level or a core signal routed by hardware indication
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      gpio_q     <= 8'h00;
      hwind_en_q <= 8'h00;
    end
    else if (ce_i)
    begin
      if (fire && e_op == CAS_OP_GPIO_SET)
      begin
        gpio_q[e_tgt]     <= e_val[0];
        hwind_en_q[e_tgt] <= 1'b0;
      end
      else if (fire && e_op == CAS_OP_HW_IND)
      begin
        hwind_en_q[e_tgt] <= 1'b1;
      end
    end
  end

  // Seconds prescaler
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sec_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      sec_q <= tick ? 32'h0000_0000 : sec_q + 32'h0000_0001;
    end
  end
  assign tick = (sec_q == 32'(CYC_PER_SEC - 1));

  generate
    for (genvar g = 0; g < 8; g++)
    begin : g_chan
      logic [TMR_W-1:0]      tmr_q;
      logic                  run_q;
      logic [`CAS_CNT_W-1:0] cnt_q;

      assign tmr_load[g] = fire && (e_op == CAS_OP_TMR_CTL) && (e_tgt == 3'(g));
      assign cnt_inc[g]  = fire && (e_op == CAS_OP_CNT_INC) && (e_tgt == 3'(g));
      assign cnt_set[g]  = fire && (e_op == CAS_OP_CNT_SET) && (e_tgt == 3'(g));
      assign cnt_o[g*`CAS_CNT_W +: `CAS_CNT_W] = cnt_q;

      // Timer: load seconds to start, zero to stop
      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          tmr_q        <= '0;
          run_q        <= 1'b0;
          tmr_exp_o[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          if (tmr_load[g])
          begin
            tmr_q        <= e_val[TMR_W-1:0];
            run_q        <= (e_val[TMR_W-1:0] != '0);
            tmr_exp_o[g] <= 1'b0;
          end
          else if (run_q && tick)
          begin
            tmr_q <= tmr_q - 1'b1;
            if (tmr_q == TMR_W'(1))
            begin
              run_q        <= 1'b0;
              tmr_exp_o[g] <= 1'b1;
            end
          end
        end
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          cnt_q <= '0;
        end
        else if (ce_i)
        begin
          if (cnt_set[g])
          begin
            cnt_q <= e_val;
          end
          else if (cnt_inc[g])
          begin
            cnt_q <= cnt_q + `CAS_CNT_INC;
          end
        end
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          hwind_sel_q[g] <= 3'h0;
          gpio_o[g]      <= 1'b0;
        end
        else if (ce_i)
        begin
          if (fire && e_op == CAS_OP_HW_IND && e_tgt == 3'(g))
          begin
            hwind_sel_q[g] <= e_val[2:0];
          end
          gpio_o[g] <= hwind_en_q[g] ? core_sig_i[hwind_sel_q[g]] : gpio_q[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> logic/cas_params.svh
// Constants of the conditional action scripter
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH

`define CAS_NPAIR        16
`define CAS_IDX_W        4
`define CAS_NTMR         8
`define CAS_NCNT         8
`define CAS_CNT_W        32
`define CAS_NCOND        16
`define CAS_MAX_TOKENS   8
`define CAS_CNT_INC      32'h0000_0001
// Timer tick: one second at the 40 ns clock
`define CAS_TICK_S       1
`define CAS_CLK_NS       40
`define CAS_CYC_PER_SEC  (`CAS_TICK_S * 1000000000 / `CAS_CLK_NS)
`define CAS_MAX_PKT_LEN  1500
// Entry layout
`define CAS_ENT_W        64
`define CAS_F_VALID      0
`define CAS_F_MASK_LO    1
`define CAS_F_MASK_HI    24
`define CAS_F_OP_LO      25
`define CAS_F_OP_HI      28
`define CAS_F_TGT_LO     29
`define CAS_F_TGT_HI     31
`define CAS_F_VAL_LO     32
`define CAS_F_VAL_HI     63
// Packet value layout
`define CAS_F_LEN_HI     15
`define CAS_F_TOK_LO     16
`define CAS_F_TOK_HI     19

`endif

// >>> logic/cas_pkg.sv
// Types of the conditional action scripter
package cas_pkg;

  typedef enum logic [3:0] {
    CAS_OP_NONE     = 4'h0,
    CAS_OP_PKT_RAW  = 4'h1,
    CAS_OP_PKT_UDP  = 4'h2,
    CAS_OP_PKT_TCP  = 4'h3,
    CAS_OP_CNT_INC  = 4'h4,
    CAS_OP_CNT_SET  = 4'h5,
    CAS_OP_TMR_CTL  = 4'h6,
    CAS_OP_GPIO_SET = 4'h7,
    CAS_OP_HIBERN   = 4'h8,
    CAS_OP_ROLE     = 4'h9,
    CAS_OP_DEL_PROF = 4'hA,
    CAS_OP_POLICY   = 4'hB,
    CAS_OP_HW_IND   = 4'hC
  } cas_op_type;

  typedef enum {
    CAS_ST_READ,
    CAS_ST_EVAL,
    CAS_ST_PKT
  } cas_state_type;

endpackage

// >>> logic/cas_mem_if.sv
// Port bundle between scripter engine and pair memory
`timescale 1ns/1ps
`default_nettype none
`include "cas_params.svh"

interface cas_mem_if;
  logic                   we;
  logic [`CAS_IDX_W-1:0]  waddr;
  logic [`CAS_ENT_W-1:0]  wdata;
  logic [`CAS_IDX_W-1:0]  raddr;
  logic [`CAS_ENT_W-1:0]  rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// >>> logic/cas_pair_mem.sv
// Condition/action pair memory with registered read
`timescale 1ns/1ps
`default_nettype none
`include "cas_params.svh"

module cas_pair_mem
  import cas_pkg::*;
#(
  parameter int DEPTH = `CAS_NPAIR
)(
  // Clock and enable
  input  wire logic clk_sys_i,
  input  wire logic ce_i,
  // Access
  cas_mem_if.mem    port
);

  logic [`CAS_ENT_W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && port.we)
    begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i)
    begin
      port.rdata <= mem_q[port.raddr];
    end
  end

endmodule

`default_nettype wire

// >>> testbench/cas_scripter_assertions.sv
// Port-level assertions of the conditional action scripter
`timescale 1ns/1ps
`default_nettype none
`include "cas_params.svh"

module cas_scripter_assertions
  import cas_pkg::*;
#(
  parameter int MAX_PKT_LEN = `CAS_MAX_PKT_LEN
)(
  // Clock and reset
  input wire logic         clk_sys_i,
  input wire logic         sys_rst_i,
  input wire logic         ce_i,
  // Configuration
  input wire logic         cfg_we_i,
  input wire logic [4:0]   cfg_idx_i,
  input wire logic         cfg_ok_o,
  input wire logic         cfg_err_o,
  // Packet request
  input wire logic         pkt_req_o,
  input wire logic [1:0]   pkt_kind_o,
  input wire logic [15:0]  pkt_len_o,
  input wire logic [3:0]   pkt_tok_o,
  input wire logic         pkt_ack_i,
  // Action results
  input wire logic         preinit_i,
  input wire logic [255:0] cnt_o,
  input wire logic [1:0]   role_o,
  input wire logic [7:0]   policy_o,
  input wire logic         del_prof_o,
  input wire logic         hib_o,
  input wire logic         act_err_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic [255:0] cnt_prev_q;
  logic [7:0]   cnt_chg;

  always_ff @(posedge clk_sys_i)
    if (sys_rst_i)
      cnt_prev_q <= '0;
    else
      cnt_prev_q <= cnt_o;

  always_comb
    for (int k = 0; k < 8; k++)
      cnt_chg[k] = cnt_o[32*k +: 32] != cnt_prev_q[32*k +: 32];

  sequence req_wait;
    pkt_req_o && !pkt_ack_i;
  endsequence

  sequence req_held;
    pkt_req_o && $stable(pkt_kind_o) && $stable(pkt_len_o) && $stable(pkt_tok_o);
  endsequence

  cfg_take_a: assert property (ce_i && cfg_we_i && !cfg_idx_i[4] |=> cfg_ok_o && !cfg_err_o)
    else $error("config write not accepted");
  cfg_refuse_a: assert property (ce_i && cfg_we_i && cfg_idx_i[4] |=> cfg_err_o && !cfg_ok_o)
    else $error("config write above last pair not refused");
  cfg_idle_a: assert property (!(ce_i && cfg_we_i) |=> !cfg_ok_o && !cfg_err_o)
    else $error("config answer without a write");
  req_hold_a: assert property (req_wait |=> req_held)
    else $error("packet request changed before acknowledge");
  req_drop_a: assert property (pkt_req_o && pkt_ack_i |=> !pkt_req_o)
    else $error("packet request held after acknowledge");
  pkt_limit_a: assert property (pkt_req_o |-> pkt_tok_o <= 4'h8
    && pkt_len_o <= MAX_PKT_LEN && pkt_kind_o != 2'h0)
    else $error("packet request beyond limits");
  one_cnt_a: assert property ($onehot0(cnt_chg))
    else $error("two counters changed in one cycle");
  hib_sticky_a: assert property (hib_o |=> hib_o)
    else $error("hibernate dropped");
  err_pulse_a: assert property (act_err_o |-> !pkt_req_o ##1 !act_err_o)
    else $error("refused packet raised a request");
  pre_only_a: assert property (del_prof_o || $changed(role_o)
    || $changed(policy_o) |-> $past(preinit_i))
    else $error("pre-init action outside pre-init");
endmodule

bind cas_scripter cas_scripter_assertions #(.MAX_PKT_LEN(MAX_PKT_LEN)) cas_scripter_assertions_i (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .cfg_we_i(cfg_we_i),
  .cfg_idx_i(cfg_idx_i), .cfg_ok_o(cfg_ok_o), .cfg_err_o(cfg_err_o), .pkt_req_o(pkt_req_o),
  .pkt_kind_o(pkt_kind_o), .pkt_len_o(pkt_len_o), .pkt_tok_o(pkt_tok_o),
  .pkt_ack_i(pkt_ack_i), .preinit_i(preinit_i), .cnt_o(cnt_o), .role_o(role_o),
  .policy_o(policy_o), .del_prof_o(del_prof_o), .hib_o(hib_o), .act_err_o(act_err_o)
);

`default_nettype wire

// >>> testbench/cas_core_model.sv
// Networking core stand-in that takes packet requests
`timescale 1ns/1ps
`default_nettype none

module cas_core_model
  import cas_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Request from the scripter
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic [15:0] len_i,
  output logic             ack_o,
  // Record of taken packets
  output logic [3:0]       seen_o,
  output logic [7:0]       npkt_o,
  output logic [15:0]      len_o
);
  logic [3:0] wait_q;

  // Slow mode stalls each request as a busy core would
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      seen_o <= 4'h0;
      npkt_o <= 8'h00;
      len_o <= 16'h0000;
    end
    else
    begin
      ack_o <= 1'b0;
      if (req_i && !ack_o)
      begin
        if (!slow_i || wait_q == 4'h6)
        begin
          ack_o <= 1'b1;
          wait_q <= 4'h0;
          seen_o[kind_i] <= 1'b1;
          npkt_o <= npkt_o + 8'h01;
          len_o <= len_i;
        end
        else
          wait_q <= wait_q + 4'h1;
      end
    end
endmodule

`default_nettype wire

// >>> testbench/tb_cas_scripter.sv
// Self-checking bench of the conditional action scripter
`timescale 1ns/1ps
`default_nettype none
`include "cas_params.svh"

module tb_cas_scripter
  import cas_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         we = 1'b0;
  logic [4:0]   idx = 5'h00;
  logic [63:0]  dat = 64'h0;
  logic         pre = 1'b0;
  logic [15:0]  cond = 16'h0000;
  logic [7:0]   core = 8'h00;
  logic         slow = 1'b1;
  logic         ok, err, req, ack, del, hib, aerr;
  logic [1:0]   kind, role;
  logic [15:0]  len, mlen;
  logic [3:0]   tok, seen;
  logic [7:0]   gpio, pol, texp, npkt;
  logic [255:0] cnt;
  int           miscompares = 0;
  int           checks = 0;
  int           n_err = 0;
  int           n_del = 0;
  logic [3:0]   tok_or = 4'h0;

  always #20 clk = ~clk;

  always @(posedge clk)
  begin
    if (aerr === 1'b1) n_err++;
    if (del === 1'b1) n_del++;
    if (req === 1'b1 && ack === 1'b1) tok_or = tok_or | tok;
  end

  cas_scripter #(.CYC_PER_SEC(10)) cas_scripter_i (
    .clk_sys_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .cfg_we_i(we), .cfg_idx_i(idx),
    .cfg_data_i(dat), .cfg_ok_o(ok), .cfg_err_o(err), .preinit_i(pre), .cond_i(cond),
    .core_sig_i(core), .pkt_req_o(req), .pkt_kind_o(kind), .pkt_len_o(len),
    .pkt_tok_o(tok), .pkt_ack_i(ack), .gpio_o(gpio), .cnt_o(cnt), .tmr_exp_o(texp),
    .role_o(role), .policy_o(pol), .del_prof_o(del), .hib_o(hib), .act_err_o(aerr)
  );

  cas_core_model cas_core_model_i (
    .clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(req), .kind_i(kind), .len_i(len),
    .ack_o(ack), .seen_o(seen), .npkt_o(npkt), .len_o(mlen)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [31:0] c(input int k);
    return cnt[32*k +: 32];
  endfunction

  function automatic logic [63:0] ent(input logic [23:0] m, input logic [3:0] op,
                                      input logic [2:0] t, input logic [31:0] v);
    return {v, t, op, m, 1'b1};
  endfunction

  // Writes stay back to back; caller lowers the strobe
  task automatic wr(input logic [4:0] i, input logic [63:0] d, input logic bad);
    we = 1'b1;
    idx = i;
    dat = d;
    step(1);
    chk("cfg_ok", ok, !bad);
    chk("cfg_err", err, bad);
  endtask

  task automatic t_cfg();
    logic [63:0] tbl [16];
    tbl = '{ent(24'h00_0001, CAS_OP_CNT_SET, 3'h3, 32'hFFFF_FFFF),
      ent(24'h00_0001, CAS_OP_CNT_INC, 3'h3, 32'h0), ent(24'h00_0003, CAS_OP_CNT_INC, 3'h4, 32'h0),
      ent(24'h00_0004, CAS_OP_PKT_RAW, 3'h0, 32'h0008_0064),
      ent(24'h00_0004, CAS_OP_PKT_UDP, 3'h0, 32'h0000_05DC),
      ent(24'h00_0004, CAS_OP_PKT_TCP, 3'h0, 32'h0000_0001),
      ent(24'h00_0004, CAS_OP_PKT_UDP, 3'h0, 32'h0009_0001),
      ent(24'h00_0008, CAS_OP_ROLE, 3'h0, 32'h2), ent(24'h00_0008, CAS_OP_POLICY, 3'h0, 32'h5A),
      ent(24'h00_0008, CAS_OP_DEL_PROF, 3'h0, 32'h0), ent(24'h00_0008, CAS_OP_HW_IND, 3'h5, 32'h3),
      ent(24'h00_0010, CAS_OP_TMR_CTL, 3'h2, 32'h3), ent(24'h04_0000, CAS_OP_CNT_INC, 3'h5, 32'h0),
      ent(24'h00_0020, CAS_OP_GPIO_SET, 3'h6, 32'h1), ent(24'h00_0020, CAS_OP_HIBERN, 3'h0, 32'h0),
      ent(24'h00_0004, CAS_OP_PKT_RAW, 3'h0, 32'h0000_05DD)};
    for (int i = 0; i < 16; i++)
      wr(5'(i), tbl[i], 1'b0);
    wr(5'h10, tbl[1], 1'b1);
    wr(5'h1F, tbl[1], 1'b1);
    we = 1'b0;
    // One full scan so no pair keeps an edge history from unwritten memory
    step(32);
    $display("test cfg done");
  endtask

  task automatic t_cnt();
    cond[0] = 1'b1;
    step(40);
    chk("cnt3", c(3), 32'h0000_0000);
    chk("cnt4", c(4), 32'h0000_0000);
    cond[1] = 1'b1;
    step(40);
    chk("cnt4", c(4), 32'h0000_0001);
    cond[0] = 1'b0;
    step(40);
    cond[0] = 1'b1;
    step(40);
    chk("cnt4", c(4), 32'h0000_0002);
    chk("cnt3", c(3), 32'h0000_0000);
    $display("test cnt done");
  endtask

  task automatic t_pkt();
    cond[2] = 1'b1;
    step(100);
    chk("kinds", seen, 4'hE);
    chk("npkt", npkt, 8'h03);
    chk("len", mlen, 16'h0001);
    chk("refused", n_err, 2);
    chk("tokens", tok_or, 4'h8);
    slow = 1'b0;
    cond[2] = 1'b0;
    step(40);
    cond[2] = 1'b1;
    step(60);
    chk("npkt", npkt, 8'h06);
    chk("refused", n_err, 4);
    $display("test pkt done");
  endtask

  task automatic t_pre();
    core = 8'h08;
    cond[3] = 1'b1;
    step(40);
    chk("role", role, 2'h0);
    chk("dels", n_del, 0);
    chk("gpio5", gpio[5], 1'b0);
    cond[3] = 1'b0;
    pre = 1'b1;
    step(40);
    cond[3] = 1'b1;
    step(40);
    chk("role", role, 2'h2);
    chk("policy", pol, 8'h5A);
    chk("dels", n_del, 1);
    chk("gpio5", gpio[5], 1'b1);
    core = 8'h00;
    step(2);
    chk("gpio5", gpio[5], 1'b0);
    pre = 1'b0;
    $display("test pre done");
  endtask

  task automatic t_tmr();
    int n;
    n = 0;
    cond[4] = 1'b1;
    while (texp[2] !== 1'b1 && n < 200)
    begin
      step(1);
      n++;
    end
    chk("expiry", n >= 20 && n <= 72, 1'b1);
    chk("tmr_exp", texp, 8'h04);
    step(40);
    chk("cnt5", c(5), 32'h0000_0001);
    cond[5] = 1'b1;
    step(40);
    chk("gpio6", gpio[6], 1'b1);
    chk("hib", hib, 1'b1);
    $display("test tmr done");
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial
  begin
    step(4);
    rst = 1'b0;
    t_cfg();
    t_cnt();
    t_pkt();
    t_pre();
    t_tmr();
    summarize();
  end
endmodule

`default_nettype wire
